// *** hdl/hwlu_defines.svh ***
// Constants for the half-word load unit.
`ifndef HWLU_DEFINES_SVH
`define HWLU_DEFINES_SVH
`define HWLU_DATA_W 32
`define HWLU_HALF_W 16
`define HWLU_ADDR_W 32
`define HWLU_STEP 32'h0000_0002
`define HWLU_NUM_DREG 8
`define HWLU_NUM_PREG 8
`define HWLU_NUM_IREG 4
`define HWLU_OP_UPPER 3'h0
`define HWLU_OP_LOWER 3'h1
`define HWLU_OP_ZEXT 3'h2
`define HWLU_OP_SEXT 3'h3
`define HWLU_MODE_IND 3'h0
`define HWLU_MODE_INC 3'h1
`define HWLU_MODE_DEC 3'h2
`define HWLU_MODE_PIDX 3'h3
`endif

// *** hdl/hwlu_pkg.sv ***
// Types shared by the half-word load unit modules.
package hwlu_pkg;
  typedef enum logic [2:0] {
    HWLU_UPPER,
    HWLU_LOWER,
    HWLU_ZEXT,
    HWLU_SEXT
  } hwlu_op_t;

  typedef enum logic [2:0] {
    HWLU_IND,
    HWLU_INC,
    HWLU_DEC,
    HWLU_PIDX
  } hwlu_mode_t;

  // One decoded load request.
  typedef struct packed {
    hwlu_op_t op;
    hwlu_mode_t mode;
    logic use_index;
    logic [2:0] dst;
    logic [2:0] src1;
    logic [2:0] src2;
    logic long_enc;
  } hwlu_req_t;

  // One register file write back.
  typedef struct packed {
    logic valid;
    logic [2:0] dst;
    logic [31:0] value;
  } hwlu_wb_t;
endpackage

// *** hdl/hwlu_circ.sv ***
// Circular index post-modify arithmetic for the half-word load unit.
`timescale 1ns/1ps
`include "hwlu_defines.svh"
module hwlu_circ
  import hwlu_pkg::*;
(
  input wire logic [31:0] index_in, // Current index value.
  input wire logic [31:0] length_in, // Buffer length in bytes.
  input wire logic [31:0] base_in, // Buffer base address.
  input wire logic decrement_in, // High to step down.
  output logic [31:0] next_out // Post-modified index.
);
  logic [31:0] raw;
  logic [31:0] limit;

  // Step by one half-word, then fold back into the window when length is nonzero.
  always_comb begin
    raw = decrement_in ? index_in - `HWLU_STEP : index_in + `HWLU_STEP;
    limit = base_in + length_in;
    next_out = raw;
    if (length_in != 32'h0000_0000) begin
      if (!decrement_in && (raw >= limit)) begin
        next_out = raw - length_in;
      end else if (decrement_in && (raw < base_in)) begin
        next_out = raw + length_in;
      end
    end
  end
endmodule

// *** hdl/hwlu_merge.sv ***
// Merges a loaded half-word into a data register value.
`timescale 1ns/1ps
`include "hwlu_defines.svh"
module hwlu_merge
  import hwlu_pkg::*;
(
  input wire hwlu_op_t op_in, // Load flavour.
  input wire logic [31:0] old_in, // Current register value.
  input wire logic [15:0] half_in, // Half-word from memory.
  output logic [31:0] value_out // New register value.
);
  // Only the addressed half changes for the half-register forms.
  always_comb begin
    case (op_in)
      HWLU_UPPER: value_out = {half_in, old_in[15:0]};
      HWLU_LOWER: value_out = {old_in[31:16], half_in};
      HWLU_SEXT: value_out = {{16{half_in[15]}}, half_in};
      default: value_out = {16'h0000, half_in};
    endcase
  end
endmodule

// *** hdl/hwlu_top.sv ***
// Half-word load execution unit: address, memory access, write back, post-modify.
`timescale 1ns/1ps
`include "hwlu_defines.svh"
module hwlu_top
  import hwlu_pkg::*;
(
  input wire logic mclk_in, // Core clock, 20 MHz.
  input wire logic reset_n_in, // Synchronous reset, active low.
  input wire logic req_valid_in, // A load request is offered.
  input wire hwlu_req_t req_in, // Decoded load request.
  output logic req_ready_out, // Unit can accept a request.
  output logic pair_ok_out, // Request may issue in parallel.
  output logic mem_rd_out, // Memory read strobe.
  output logic [31:0] mem_addr_out, // Memory byte address.
  input wire logic mem_ack_in, // Memory read data valid.
  input wire logic [15:0] mem_data_in, // Memory half-word.
  output logic [31:0] dreg_out [8], // Data register file contents.
  output logic [31:0] preg_out [8], // Pointer register contents.
  output logic misalign_out, // Misaligned exception pulse.
  output logic done_out, // Load completed pulse.
  input wire logic cfg_we_in, // Software write to address registers.
  input wire logic [1:0] cfg_sel_in, // 0 index, 1 length, 2 base, 3 pointer.
  input wire logic [2:0] cfg_idx_in, // Register number.
  input wire logic [31:0] cfg_data_in // Write value.
);
  typedef enum logic [1:0] {
    HWLU_IDLE,
    HWLU_WAIT
  } hwlu_state_t;

  hwlu_state_t state_r, state_nxt;
  hwlu_req_t cur_r, cur_nxt;
  logic [31:0] addr_r, addr_nxt;
  logic misalign_r, misalign_nxt;
  logic done_r, done_nxt;
  logic [31:0] dreg_r [8];
  logic [31:0] dreg_nxt [8];
  logic [31:0] preg_r [8];
  logic [31:0] preg_nxt [8];
  logic [31:0] ireg_r [4];
  logic [31:0] ireg_nxt [4];
  logic [31:0] lreg_r [4];
  logic [31:0] lreg_nxt [4];
  logic [31:0] breg_r [4];
  logic [31:0] breg_nxt [4];
  logic [31:0] eff_addr;
  logic [31:0] circ_next;
  logic [31:0] merged;
  logic [1:0] ii;
  logic take;

  // A request is only taken while idle; one load is in flight at a time.
  assign req_ready_out = (state_r == HWLU_IDLE);
  assign take = req_valid_in && req_ready_out;
  assign ii = req_in.src1[1:0];

  // Returns high when a request form may share an issue slot.
  function automatic logic hwlu_pairable(input hwlu_req_t r);
    if (r.op == HWLU_UPPER || r.op == HWLU_LOWER) begin
      hwlu_pairable = 1'b1;
    end else begin
      hwlu_pairable = !r.long_enc;
    end
  endfunction

  assign pair_ok_out = req_valid_in && hwlu_pairable(req_in);

  // The access always uses the register value before any post-modify.
  always_comb begin
    eff_addr = req_in.use_index ? ireg_r[ii] : preg_r[req_in.src1];
  end

  hwlu_circ u_circ (
    .index_in(ireg_r[ii]),
    .length_in(lreg_r[ii]),
    .base_in(breg_r[ii]),
    .decrement_in(req_in.mode == HWLU_DEC),
    .next_out(circ_next)
  );

  hwlu_merge u_merge (
    .op_in(cur_r.op),
    .old_in(dreg_r[cur_r.dst]),
    .half_in(mem_data_in),
    .value_out(merged)
  );

  // Control state: issue, wait for memory, report completion or fault.
  always_comb begin
    state_nxt = state_r;
    cur_nxt = cur_r;
    addr_nxt = addr_r;
    misalign_nxt = 1'b0;
    done_nxt = 1'b0;
    case (state_r)
      HWLU_IDLE: begin
        if (take) begin
          if (eff_addr[0]) begin
            misalign_nxt = 1'b1;
          end else begin
            cur_nxt = req_in;
            addr_nxt = eff_addr;
            state_nxt = HWLU_WAIT;
          end
        end
      end
      HWLU_WAIT: begin
        if (mem_ack_in) begin
          done_nxt = 1'b1;
          state_nxt = HWLU_IDLE;
        end
      end
      default: state_nxt = HWLU_IDLE;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      state_r <= HWLU_IDLE;
      cur_r <= '0;
      addr_r <= 32'h0000_0000;
      misalign_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cur_r <= cur_nxt;
      addr_r <= addr_nxt;
      misalign_r <= misalign_nxt;
      done_r <= done_nxt;
    end
  end

  // Data registers: only the completing load writes its destination.
  always_comb begin
    for (int k = 0; k < `HWLU_NUM_DREG; k++) begin
      dreg_nxt[k] = dreg_r[k];
    end
    if (state_r == HWLU_WAIT && mem_ack_in) begin
      dreg_nxt[cur_r.dst] = merged;
    end
  end

  // Address registers: post-modify happens at issue, software writes win on a clash.
  always_comb begin
    for (int k = 0; k < `HWLU_NUM_PREG; k++) begin
      preg_nxt[k] = preg_r[k];
    end
    for (int k = 0; k < `HWLU_NUM_IREG; k++) begin
      ireg_nxt[k] = ireg_r[k];
      lreg_nxt[k] = lreg_r[k];
      breg_nxt[k] = breg_r[k];
    end
    if (take && !eff_addr[0]) begin
      if (req_in.use_index) begin
        if (req_in.mode == HWLU_INC || req_in.mode == HWLU_DEC) begin
          ireg_nxt[ii] = circ_next;
        end
      end else if (req_in.mode == HWLU_PIDX && req_in.src1 != req_in.src2) begin
        preg_nxt[req_in.src1] = preg_r[req_in.src1] + preg_r[req_in.src2];
      end
    end
    if (cfg_we_in) begin
      case (cfg_sel_in)
        2'h0: ireg_nxt[cfg_idx_in[1:0]] = cfg_data_in;
        2'h1: lreg_nxt[cfg_idx_in[1:0]] = cfg_data_in;
        2'h2: breg_nxt[cfg_idx_in[1:0]] = cfg_data_in;
        default: preg_nxt[cfg_idx_in] = cfg_data_in;
      endcase
    end
  end

  // Register files hold state across reset on purpose; start-up code must clear them.
  always_ff @(posedge mclk_in) begin
    dreg_r <= dreg_nxt;
    preg_r <= preg_nxt;
    ireg_r <= ireg_nxt;
    lreg_r <= lreg_nxt;
    breg_r <= breg_nxt;
  end

  assign mem_rd_out = (state_r == HWLU_WAIT);
  assign mem_addr_out = addr_r;
  assign misalign_out = misalign_r;
  assign done_out = done_r;
  assign dreg_out = dreg_r;
  assign preg_out = preg_r;
endmodule

// *** tb/hwlu_mem_model.sv ***
// Behavioural core data memory that answers half-word reads.
`timescale 1ns/1ps
module hwlu_mem_model
  import hwlu_pkg::*;
(
  input wire logic clk_in, // Core clock.
  input wire logic rd_in, // Read strobe.
  input wire logic [31:0] addr_in, // Byte address.
  input wire logic [1:0] wait_in, // Idle cycles before ack.
  output logic ack_out, // Data valid pulse.
  output logic [15:0] data_out // Half-word.
);
  logic [1:0] cnt_r = 2'h0;
  logic [15:0] val;
  // Outside the ack cycle the bus shows the inverse, so stale data never matches.
  assign val = addr_in[15:0] ^ 16'h8421;
  assign data_out = ack_out ? val : ~val;
  // One ack for each read, after wait_in idle cycles.
  always_ff @(posedge clk_in) begin
    ack_out <= 1'b0;
    if (rd_in && !ack_out) begin
      ack_out <= (cnt_r == wait_in);
      cnt_r <= (cnt_r == wait_in) ? 2'h0 : cnt_r + 2'h1;
    end
  end
endmodule

// *** tb/hwlu_top_chk.sv ***
// Port assertions for the half-word load unit.
`timescale 1ns/1ps
module hwlu_top_chk
  import hwlu_pkg::*;
(
  input wire logic mclk_in, // Clock.
  input wire logic reset_n_in, // Reset.
  input wire logic req_valid_in, // Request.
  input wire hwlu_req_t req_in, // Decoded request.
  input wire logic req_ready_out, // Ready.
  input wire logic pair_ok_out, // Pairing.
  input wire logic mem_rd_out, // Read.
  input wire logic [31:0] mem_addr_out, // Address.
  input wire logic mem_ack_in, // Ack.
  input wire logic [31:0] preg_out [8], // Pointers.
  input wire logic misalign_out, // Exception.
  input wire logic done_out // Done.
);
  logic take;
  logic pidx;
  logic [31:0] p1;
  logic [31:0] p2;
  // Pointer loads only: index values are not visible at the ports.
  assign take = req_valid_in && req_ready_out && !req_in.use_index;
  assign pidx = take && !p1[0] && req_in.mode == HWLU_PIDX;
  assign p1 = preg_out[req_in.src1];
  assign p2 = preg_out[req_in.src2];
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);
  odd_addr_trap_a: assert property (take && p1[0] |=> misalign_out && !mem_rd_out)
    else $error("odd address not trapped");
  ptr_addr_a: assert property (take && !p1[0] |=> mem_rd_out && mem_addr_out == $past(p1))
    else $error("wrong read address");
  pidx_step_a: assert property (pidx && req_in.src1 != req_in.src2
    |=> preg_out[$past(req_in.src1)] == $past(p1 + p2)) else $error("pointer not stepped");
  pidx_same_a: assert property (pidx && req_in.src1 == req_in.src2
    |=> preg_out[$past(req_in.src1)] == $past(p1)) else $error("pointer moved");
  rd_hold_a: assert property (mem_rd_out && !mem_ack_in |=> mem_rd_out && $stable(mem_addr_out))
    else $error("read dropped early");
  done_ack_a: assert property (mem_rd_out && mem_ack_in |=> done_out && !mem_rd_out)
    else $error("no done after ack");
  sext_long_a: assert property (req_valid_in && req_in.op == HWLU_SEXT && req_in.long_enc
    |-> !pair_ok_out) else $error("long load paired");
  half_pair_a: assert property (req_valid_in && req_in.op inside {HWLU_UPPER, HWLU_LOWER}
    |-> pair_ok_out) else $error("half load not paired");
endmodule
bind hwlu_top hwlu_top_chk u_hwlu_top_chk (.mclk_in, .reset_n_in, .req_valid_in, .req_in,
  .req_ready_out, .pair_ok_out, .mem_rd_out, .mem_addr_out, .mem_ack_in, .preg_out,
  .misalign_out, .done_out);

// *** tb/tb_hwlu_top.sv ***
// Self-checking bench for the half-word load unit.
`timescale 1ns/1ps
module tb_hwlu_top import hwlu_pkg::*;;
  logic mclk_in, reset_n_in, req_valid_in, req_ready_out, pair_ok_out, mem_rd_out, mem_ack_in;
  logic misalign_out, done_out, cfg_we_in, gm;
  hwlu_req_t req_in;
  logic [31:0] mem_addr_out, cfg_data_in, ga;
  logic [31:0] dreg_out [8];
  logic [31:0] preg_out [8];
  logic [15:0] mem_data_in;
  logic [1:0] cfg_sel_in, wt;
  logic [2:0] cfg_idx_in;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;
  hwlu_top u_hwlu_top (.mclk_in, .reset_n_in, .req_valid_in, .req_in, .req_ready_out,
    .pair_ok_out, .mem_rd_out, .mem_addr_out, .mem_ack_in, .mem_data_in, .dreg_out,
    .preg_out, .misalign_out, .done_out, .cfg_we_in, .cfg_sel_in, .cfg_idx_in, .cfg_data_in);
  hwlu_mem_model u_hwlu_mem_model (.clk_in(mclk_in), .rd_in(mem_rd_out),
    .addr_in(mem_addr_out), .wait_in(wt), .ack_out(mem_ack_in), .data_out(mem_data_in));
  // A hang ends the run with a mismatch.
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      conclude();
    end
  end
  always #25 mclk_in = ~mclk_in;
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Direct write of an index, length, base or pointer register.
  task automatic cfg(input logic [1:0] s, input logic [2:0] i, input logic [31:0] d);
    @(negedge mclk_in);
    cfg_we_in = 1'b1;
    cfg_sel_in = s;
    cfg_idx_in = i;
    cfg_data_in = d;
    @(negedge mclk_in);
    cfg_we_in = 1'b0;
  endtask
  // One load; records the read address and whether it trapped.
  task automatic ld(input hwlu_op_t o, input hwlu_mode_t m, input logic u,
    input logic [2:0] d, input logic [2:0] s1, input logic [2:0] s2, input logic lg);
    @(negedge mclk_in);
    req_in = '{o, m, u, d, s1, s2, lg};
    req_valid_in = 1'b1;
    #1 chk(pair_ok_out, o <= HWLU_LOWER || !lg);
    @(negedge mclk_in);
    req_valid_in = 1'b0;
    gm = misalign_out;
    ga = mem_addr_out;
    for (int n = 0; n < 20 && !done_out && !gm; n++) @(negedge mclk_in);
    chk(done_out ^ gm, 1'b1);
  endtask
  task automatic t_halves();
    wt = 2'h2;
    cfg(2'h3, 3'h1, 32'h0000_0100);
    ld(HWLU_SEXT, HWLU_IND, 1'b0, 3'h2, 3'h1, 3'h0, 1'b1);
    chk(dreg_out[2], 32'hffff_8521);
    ld(HWLU_ZEXT, HWLU_IND, 1'b0, 3'h2, 3'h1, 3'h0, 1'b0);
    chk(dreg_out[2], 32'h0000_8521);
    cfg(2'h3, 3'h1, 32'h0000_1234);
    ld(HWLU_UPPER, HWLU_IND, 1'b0, 3'h2, 3'h1, 3'h0, 1'b1);
    chk(dreg_out[2], 32'h9615_8521);
    cfg(2'h3, 3'h1, 32'h0000_0040);
    ld(HWLU_LOWER, HWLU_IND, 1'b0, 3'h2, 3'h1, 3'h0, 1'b0);
    chk(dreg_out[2], 32'h9615_8461);
    $display("halves test done");
  endtask
  // Linear steps first, then a window of 8 bytes at 0x208 that wraps both ways.
  task automatic t_index();
    wt = 2'h0;
    cfg(2'h0, 3'h0, 32'h0000_0200);
    cfg(2'h1, 3'h0, 32'h0000_0000);
    cfg(2'h2, 3'h0, 32'h0000_0200);
    ld(HWLU_UPPER, HWLU_INC, 1'b1, 3'h3, 3'h0, 3'h0, 1'b0);
    chk(ga, 32'h0000_0200);
    ld(HWLU_LOWER, HWLU_DEC, 1'b1, 3'h3, 3'h0, 3'h0, 1'b0);
    chk(ga, 32'h0000_0202);
    ld(HWLU_LOWER, HWLU_IND, 1'b1, 3'h3, 3'h0, 3'h0, 1'b0);
    chk(ga, 32'h0000_0200);
    cfg(2'h0, 3'h1, 32'h0000_020e);
    cfg(2'h1, 3'h1, 32'h0000_0008);
    cfg(2'h2, 3'h1, 32'h0000_0208);
    ld(HWLU_UPPER, HWLU_INC, 1'b1, 3'h4, 3'h1, 3'h0, 1'b0);
    ld(HWLU_UPPER, HWLU_DEC, 1'b1, 3'h4, 3'h1, 3'h0, 1'b0);
    chk(ga, 32'h0000_0208);
    ld(HWLU_UPPER, HWLU_IND, 1'b1, 3'h4, 3'h1, 3'h0, 1'b0);
    chk(ga, 32'h0000_020e);
    $display("index test done");
  endtask
  task automatic t_pidx();
    wt = 2'h1;
    cfg(2'h3, 3'h2, 32'h0000_0300);
    cfg(2'h3, 3'h3, 32'h0000_0010);
    ld(HWLU_LOWER, HWLU_PIDX, 1'b0, 3'h5, 3'h2, 3'h3, 1'b0);
    chk(ga, 32'h0000_0300);
    chk(preg_out[2], 32'h0000_0310);
    ld(HWLU_LOWER, HWLU_PIDX, 1'b0, 3'h5, 3'h3, 3'h3, 1'b0);
    chk(preg_out[3], 32'h0000_0010);
    $display("pointer index test done");
  endtask
  task automatic t_mis();
    cfg(2'h3, 3'h4, 32'h0000_0101);
    ld(HWLU_UPPER, HWLU_IND, 1'b0, 3'h2, 3'h4, 3'h0, 1'b0);
    chk(gm, 1'b1);
    chk(dreg_out[2], 32'h9615_8461);
    $display("misalign test done");
  endtask
  initial begin
    mclk_in = 1'b0;
    reset_n_in = 1'b0;
    req_valid_in = 1'b0;
    req_in = '0;
    cfg_we_in = 1'b0;
    cfg_sel_in = 2'h0;
    cfg_idx_in = 3'h0;
    cfg_data_in = 32'h0000_0000;
    wt = 2'h0;
    repeat (12) @(negedge mclk_in);
    reset_n_in = 1'b1;
    t_halves();
    t_index();
    t_pidx();
    t_mis();
    conclude();
  end
endmodule
